// [design/dtp_consts.svh]
// Purpose: Constants for the dual timer, capture and PWM block
// Assumes: 8-bit register port, one clock at 250 MHz
// Notes:   Offsets and field positions used by the top module and the bench
//
// Overview of operation
// - Two timers run as separate 8-bit counters or joined as one 16-bit counter.
// - First timer clock: main clock over 2,4,8,32,128,512,2048 or count pin.
// - Second timer clock: main clock over 1 to 16384, or first timer overflow.
// - 8-bit timer counts its clock and interrupts when count equals match value.
// - Count pin selected: pin becomes input, first timer counts its rising edges.
// - First timer drives compare output pin; second drives its pin in timer mode.
// - Joined: first timer low byte, counts to joined match, then returns 0000H.
// - Joined match raises only the first timer interrupt.
// - Capture bit set: trigger edge copies count to capture, clears counter.
// - Capture mode still interrupts whenever the count equals the match value.
// - Data address reads capture register in capture mode, match data otherwise.
// - 16-bit capture works like 8-bit capture using joined counter, both captures.
// - PWM enable makes second timer drive three true and inverted PWM pins.
// - PWM period is period register with two high bits from bits 1:0.
// - Channel duty is duty register with two high bits from bits 7:2.
// - Polarity bit sets active level; full duty holds active, zero holds inactive.
// - Modes come jointly from join, capture, PWM, pin enables and clock selects.
`ifndef DTP_CONSTS_SVH
`define DTP_CONSTS_SVH

// ***************************************************
// Register offsets
// ***************************************************
`define DTP_OFS_MODE      8'h00
`define DTP_OFS_CLKSEL    8'h01
`define DTP_OFS_T0_DATA   8'h02
`define DTP_OFS_T1_DATA   8'h03
`define DTP_OFS_PWM_PER   8'h04
`define DTP_OFS_PWM_HIGH  8'h05
`define DTP_OFS_DUTY_A    8'h06
`define DTP_OFS_DUTY_B    8'h07
`define DTP_OFS_DUTY_C    8'h08
`define DTP_OFS_POLARITY  8'h09
`define DTP_OFS_T0_COUNT  8'h0A
`define DTP_OFS_T1_COUNT  8'h0B

// ***************************************************
// Reset values and codes
// ***************************************************
`define DTP_RST_BYTE      8'h00
`define DTP_T0_SEL_EXT    3'h7
`define DTP_T1_SEL_OVF    4'hF
`define DTP_PRESC_W       14
`define DTP_PWM_W         10

`endif

// [design/dtp_pkg.sv]
// Purpose: Types for the dual timer, capture and PWM block
// Assumes: Constants header holds all numbers
// Notes:   Structs carry grouped signals
package dtp_pkg;

   // Register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } dtp_bus_req_t;

   // Mode register layout, bit 7 down to bit 0
   typedef struct packed {
      logic       run1;
      logic       run0;
      logic [1:0] pin_enable_pair;
      logic       pwm_output_enable;
      logic       second_capture_enable;
      logic       first_capture_enable;
      logic       join_sixteen_bit;
   } dtp_mode_t;

   // Six PWM pins
   typedef struct packed {
      logic a;
      logic ab;
      logic b;
      logic bb;
      logic c;
      logic cb;
   } dtp_pwm_pins_t;

endpackage

// [design/dtp_prescaler.sv]
// Purpose: Free running divider giving power-of-two enable pulses
// Assumes: Single clock domain
// Notes:   tick_o[k] pulses once every 2**k cycles
`timescale 1ns/10ps
`default_nettype none
module dtp_prescaler #(
   parameter int W = 14
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         reset_i,
   // Enable pulses
   output logic [W:0]        tick_o
);
   logic [W-1:0] cnt_r;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   assign tick_o[0] = 1'b1;
   for (genvar k = 1; k <= W; k++) begin : g_tap
      assign tick_o[k] = &cnt_r[k-1:0];
   end
endmodule
`default_nettype wire

// [design/dtp_pwm_channel.sv]
// Purpose: One PWM channel with true and inverted outputs
// Assumes: Counter runs 0 to period minus one
// Notes:   Outputs are registered
`timescale 1ns/10ps
`default_nettype none
module dtp_pwm_channel #(
   parameter int W = 10
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         reset_i,
   // Control
   input  wire logic         en_i,
   input  wire logic [W-1:0] cnt_i,
   input  wire logic [W-1:0] duty_i,
   input  wire logic         pol_i,
   // Pins
   output logic              true_o,
   output logic              inv_o
);
   logic level;

   // Active while below duty; full duty always active, zero never
   assign level = (cnt_i < duty_i) ? pol_i : ~pol_i;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         true_o <= 1'b0;
         inv_o  <= 1'b0;
      end else if (en_i) begin
         true_o <= level;
         inv_o  <= ~level;
      end else begin
         true_o <= 1'b0;
         inv_o  <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// [design/dtp_top.sv]
// Purpose: Two 8-bit timers, joinable to 16 bits, with capture and PWM
// Assumes: Pins arrive asynchronously; register port on clk_i
// Notes:   Slow rates are enable pulses from one prescaler
`timescale 1ns/10ps
`default_nettype none
`include "dtp_consts.svh"
module dtp_top (
   // Clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 reset_i,
   // Register port
   input  wire dtp_pkg::dtp_bus_req_t bus_i,
   output logic [7:0]                rdata_o,
   // Count pin
   input  wire logic                 external_count_pin_i,
   output logic                      ext_count_input_o,
   // Capture triggers
   input  wire logic                 first_capture_trigger_input_i,
   input  wire logic                 second_capture_trigger_input_i,
   // Timer interrupts
   output logic                      first_timer_irq_o,
   output logic                      second_timer_irq_o,
   // Timer output pins
   output logic                      first_timer_output_pin_o,
   output logic                      first_timer_output_oe_n_o,
   output logic                      second_timer_output_pin_o,
   output logic                      second_timer_output_oe_n_o,
   // PWM pins
   output dtp_pkg::dtp_pwm_pins_t    pwm_pins_o,
   output logic                      pwm_oe_n_o
);
   import dtp_pkg::*;

   // ***************************************************
   // Registers
   // ***************************************************
   dtp_mode_t                mode_r;
   logic [2:0]               t0_sel_r;
   logic [3:0]               t1_sel_r;
   logic [7:0]               t0_data_r;
   logic [7:0]               t1_data_r;
   logic [7:0]               pwm_per_r;
   logic [7:0]               pwm_high_r;
   logic [7:0]               duty_a_r;
   logic [7:0]               duty_b_r;
   logic [7:0]               duty_c_r;
   logic [2:0]               pol_r;
   logic [7:0]               t0_cnt_r;
   logic [7:0]               t1_cnt_r;
   logic [7:0]               first_capture_enable_r;
   logic [7:0]               second_capture_enable_r;
   logic [7:0]               rdata_r;
   logic                     t0_irq_r;
   logic                     t1_irq_r;
   logic                     t0_out_r;
   logic                     t1_out_r;
   logic [`DTP_PWM_W-1:0]    pwm_cnt_r;

   // ***************************************************
   // Synchronisers
   // ***************************************************
   logic [2:0]               ec_sync_r;
   logic [2:0]               trig0_sync_r;
   logic [2:0]               trig1_sync_r;
   logic                     ec_rise;
   logic                     trig0_edge;
   logic                     trig1_edge;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ec_sync_r    <= 3'h0;
         trig0_sync_r <= 3'h0;
         trig1_sync_r <= 3'h0;
      end else begin
         ec_sync_r    <= {ec_sync_r[1:0], external_count_pin_i};
         trig0_sync_r <= {trig0_sync_r[1:0], first_capture_trigger_input_i};
         trig1_sync_r <= {trig1_sync_r[1:0], second_capture_trigger_input_i};
      end
   end

   // Rising edges, read from second and third stages only
   assign ec_rise    = ec_sync_r[1] & ~ec_sync_r[2];
   assign trig0_edge = trig0_sync_r[1] & ~trig0_sync_r[2];
   assign trig1_edge = trig1_sync_r[1] & ~trig1_sync_r[2];

   // ***************************************************
   // Clock selection
   // ***************************************************
   logic [`DTP_PRESC_W:0]    tick;
   logic                     t0_tick;
   logic                     t1_tick;
   logic                     t0_ovf;
   logic                     join16;

   dtp_prescaler #(
      .W (`DTP_PRESC_W)
   ) u_presc (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .tick_o  (tick)
   );

   always_comb begin
      case (t0_sel_r)
         3'h0:    t0_tick = tick[1];
         3'h1:    t0_tick = tick[2];
         3'h2:    t0_tick = tick[3];
         3'h3:    t0_tick = tick[5];
         3'h4:    t0_tick = tick[7];
         3'h5:    t0_tick = tick[9];
         3'h6:    t0_tick = tick[11];
         default: t0_tick = ec_rise;
      endcase
   end

   // Second timer never sees the count pin
   assign t1_tick = (t1_sel_r == `DTP_T1_SEL_OVF) ? t0_ovf : tick[t1_sel_r];

   // Joined only with second select at overflow code
   assign join16 = mode_r.join_sixteen_bit & (t1_sel_r == `DTP_T1_SEL_OVF);

   assign ext_count_input_o = (t0_sel_r == `DTP_T0_SEL_EXT);

   // ***************************************************
   // Counter control
   // ***************************************************
   logic                     t0_step;
   logic                     t1_step;
   logic                     hit0;
   logic                     hit1;
   logic                     hit16;
   logic                     cap_trig0;
   logic                     cap_trig1;
   logic [15:0]              cnt16_inc;
   logic                     t0_event;
   logic                     t1_event;

   assign t0_step   = mode_r.run0 & t0_tick;
   assign t1_step   = mode_r.run1 & t1_tick & ~mode_r.pwm_output_enable;
   assign hit0      = (t0_cnt_r == t0_data_r);
   assign hit1      = (t1_cnt_r == t1_data_r);
   assign hit16     = ({t1_cnt_r, t0_cnt_r} == {t1_data_r, t0_data_r});
   assign cnt16_inc = {t1_cnt_r, t0_cnt_r} + 16'h0001;
   assign cap_trig0 = mode_r.first_capture_enable & trig0_edge;
   assign cap_trig1 = mode_r.second_capture_enable & trig1_edge & ~join16;
   assign t0_ovf    = t0_step & hit0 & ~join16;

   // Match events keep firing in capture mode too
   assign t0_event = t0_step & (join16 ? hit16 : hit0);
   assign t1_event = t1_step & hit1 & ~join16;

   // ***************************************************
   // Counters
   // ***************************************************
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         t0_cnt_r <= `DTP_RST_BYTE;
         t1_cnt_r <= `DTP_RST_BYTE;
      end else if (join16) begin
         if (cap_trig0) begin
            t0_cnt_r <= 8'h00;
            t1_cnt_r <= 8'h00;
         end else if (t0_step) begin
            t0_cnt_r <= hit16 ? 8'h00 : cnt16_inc[7:0];
            t1_cnt_r <= hit16 ? 8'h00 : cnt16_inc[15:8];
         end
      end else begin
         if (cap_trig0) begin
            t0_cnt_r <= 8'h00;
         end else if (t0_step) begin
            t0_cnt_r <= hit0 ? 8'h00 : t0_cnt_r + 8'h01;
         end
         if (cap_trig1) begin
            t1_cnt_r <= 8'h00;
         end else if (t1_step) begin
            t1_cnt_r <= hit1 ? 8'h00 : t1_cnt_r + 8'h01;
         end
      end
   end

   // ***************************************************
   // Capture registers
   // ***************************************************
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         first_capture_enable_r <= `DTP_RST_BYTE;
         second_capture_enable_r <= `DTP_RST_BYTE;
      end else begin
         if (cap_trig0) begin
            first_capture_enable_r <= t0_cnt_r;
         end
         if (cap_trig0 & join16) begin
            second_capture_enable_r <= t1_cnt_r;
         end else if (cap_trig1) begin
            second_capture_enable_r <= t1_cnt_r;
         end
      end
   end

   // ***************************************************
   // Interrupts and timer pins
   // ***************************************************
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         t0_irq_r <= 1'b0;
         t1_irq_r <= 1'b0;
      end else begin
         t0_irq_r <= t0_event;
         t1_irq_r <= t1_event;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         t0_out_r <= 1'b0;
         t1_out_r <= 1'b0;
      end else begin
         if (t0_event) begin
            t0_out_r <= ~t0_out_r;
         end
         if (t1_event) begin
            t1_out_r <= ~t1_out_r;
         end
      end
   end

   assign first_timer_irq_o          = t0_irq_r;
   assign second_timer_irq_o         = t1_irq_r;
   assign first_timer_output_pin_o   = t0_out_r;
   assign first_timer_output_oe_n_o  = ~mode_r.pin_enable_pair[0];
   assign second_timer_output_pin_o  = t1_out_r;
   assign second_timer_output_oe_n_o = ~(mode_r.pin_enable_pair[1] & ~mode_r.pwm_output_enable);

   // ***************************************************
   // PWM
   // ***************************************************
   logic [`DTP_PWM_W-1:0]    pwm_period;
   logic [`DTP_PWM_W-1:0]    duty_a;
   logic [`DTP_PWM_W-1:0]    duty_b;
   logic [`DTP_PWM_W-1:0]    duty_c;
   logic [`DTP_PWM_W:0]      pwm_inc;
   logic                     pwm_on;
   logic                     pwm_tick;

   assign pwm_period = {pwm_high_r[1:0], pwm_per_r};
   assign duty_a     = {pwm_high_r[7:6], duty_a_r};
   assign duty_b     = {pwm_high_r[5:4], duty_b_r};
   assign duty_c     = {pwm_high_r[3:2], duty_c_r};
   assign pwm_on     = mode_r.pwm_output_enable;
   assign pwm_tick   = pwm_on & mode_r.run1 & t1_tick;
   assign pwm_inc    = {1'b0, pwm_cnt_r} + 11'h001;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         pwm_cnt_r <= '0;
      end else if (!pwm_on) begin
         pwm_cnt_r <= '0;
      end else if (pwm_tick) begin
         // Restart at end of period
         if (pwm_inc >= {1'b0, pwm_period}) begin
            pwm_cnt_r <= '0;
         end else begin
            pwm_cnt_r <= pwm_inc[`DTP_PWM_W-1:0];
         end
      end
   end

   dtp_pwm_channel #(
      .W (`DTP_PWM_W)
   ) u_ch_a (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .en_i    (pwm_on),
      .cnt_i   (pwm_cnt_r),
      .duty_i  (duty_a),
      .pol_i   (pol_r[0]),
      .true_o  (pwm_pins_o.a),
      .inv_o   (pwm_pins_o.ab)
   );

   dtp_pwm_channel #(
      .W (`DTP_PWM_W)
   ) u_ch_b (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .en_i    (pwm_on),
      .cnt_i   (pwm_cnt_r),
      .duty_i  (duty_b),
      .pol_i   (pol_r[1]),
      .true_o  (pwm_pins_o.b),
      .inv_o   (pwm_pins_o.bb)
   );

   dtp_pwm_channel #(
      .W (`DTP_PWM_W)
   ) u_ch_c (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .en_i    (pwm_on),
      .cnt_i   (pwm_cnt_r),
      .duty_i  (duty_c),
      .pol_i   (pol_r[2]),
      .true_o  (pwm_pins_o.c),
      .inv_o   (pwm_pins_o.cb)
   );

   assign pwm_oe_n_o = ~pwm_on;

   // ***************************************************
   // Register writes
   // ***************************************************
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         mode_r     <= dtp_mode_t'(`DTP_RST_BYTE);
         t0_sel_r   <= 3'h0;
         t1_sel_r   <= 4'h0;
         t0_data_r  <= `DTP_RST_BYTE;
         t1_data_r  <= `DTP_RST_BYTE;
         pwm_per_r  <= `DTP_RST_BYTE;
         pwm_high_r <= `DTP_RST_BYTE;
         duty_a_r   <= `DTP_RST_BYTE;
         duty_b_r   <= `DTP_RST_BYTE;
         duty_c_r   <= `DTP_RST_BYTE;
         pol_r      <= 3'h0;
      end else if (bus_i.wr) begin
         case (bus_i.addr)
            `DTP_OFS_MODE:     mode_r     <= dtp_mode_t'(bus_i.wdata);
            `DTP_OFS_CLKSEL: begin
               t0_sel_r <= bus_i.wdata[2:0];
               t1_sel_r <= bus_i.wdata[7:4];
            end
            `DTP_OFS_T0_DATA:  t0_data_r  <= bus_i.wdata;
            `DTP_OFS_T1_DATA:  t1_data_r  <= bus_i.wdata;
            `DTP_OFS_PWM_PER:  pwm_per_r  <= bus_i.wdata;
            `DTP_OFS_PWM_HIGH: pwm_high_r <= bus_i.wdata;
            `DTP_OFS_DUTY_A:   duty_a_r   <= bus_i.wdata;
            `DTP_OFS_DUTY_B:   duty_b_r   <= bus_i.wdata;
            `DTP_OFS_DUTY_C:   duty_c_r   <= bus_i.wdata;
            `DTP_OFS_POLARITY: pol_r      <= bus_i.wdata[2:0];
            default: begin
            end
         endcase
      end
   end

   // ***************************************************
   // Register reads
   // ***************************************************
   logic [7:0] rd_mux;

   always_comb begin
      case (bus_i.addr)
         `DTP_OFS_MODE:     rd_mux = mode_r;
         `DTP_OFS_CLKSEL:   rd_mux = {t1_sel_r, 1'b0, t0_sel_r};
         // Shared address shows capture in capture mode
         `DTP_OFS_T0_DATA:  rd_mux = mode_r.first_capture_enable ? first_capture_enable_r : t0_data_r;
         `DTP_OFS_T1_DATA:  rd_mux = (mode_r.second_capture_enable |
                                      (join16 & mode_r.first_capture_enable)) ? second_capture_enable_r : t1_data_r;
         `DTP_OFS_PWM_PER:  rd_mux = pwm_per_r;
         `DTP_OFS_PWM_HIGH: rd_mux = pwm_high_r;
         `DTP_OFS_DUTY_A:   rd_mux = duty_a_r;
         `DTP_OFS_DUTY_B:   rd_mux = duty_b_r;
         `DTP_OFS_DUTY_C:   rd_mux = duty_c_r;
         `DTP_OFS_POLARITY: rd_mux = {5'h00, pol_r};
         `DTP_OFS_T0_COUNT: rd_mux = t0_cnt_r;
         `DTP_OFS_T1_COUNT: rd_mux = t1_cnt_r;
         default:           rd_mux = 8'h00;
      endcase
   end

   // Data stand only in the cycle after the strobe
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         rdata_r <= 8'h00;
      end else if (bus_i.rd) begin
         rdata_r <= rd_mux;
      end else begin
         rdata_r <= 8'h00;
      end
   end

   assign rdata_o = rdata_r;

endmodule
`default_nettype wire

// [tb/dtp_checker.sv]
// Purpose: Port assertions for the dual timer block
// Assumes: Sees dtp_top ports only, one clock domain
// Notes:   Bound to dtp_top after the module
`timescale 1ns/10ps
`default_nettype none
module dtp_checker (
   // Clock and reset
   input wire logic                  clk_i,
   input wire logic                  reset_i,
   // Watched ports
   input wire dtp_pkg::dtp_bus_req_t bus_i,
   input wire logic [7:0]            rdata_o,
   input wire logic                  first_timer_irq_o,
   input wire logic                  second_timer_irq_o,
   input wire logic                  first_timer_output_pin_o,
   input wire logic                  second_timer_output_pin_o,
   input wire logic                  second_timer_output_oe_n_o,
   input wire dtp_pkg::dtp_pwm_pins_t pwm_pins_o,
   input wire logic                  pwm_oe_n_o
);
   import dtp_pkg::*;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);
   // ***************************************************
   // Assertions
   // ***************************************************
   a_read_data_idle: assert property (!$past(bus_i.rd) |-> rdata_o == 8'h00)
      else $error("read data outside its slot");
   a_first_irq_pulse: assert property (first_timer_irq_o |=> !first_timer_irq_o [*3])
      else $error("first interrupt not a lone pulse");
   a_second_irq_pulse: assert property (second_timer_irq_o |=> !second_timer_irq_o [*3])
      else $error("second interrupt not a lone pulse");
   a_first_pin_toggle: assert property (first_timer_irq_o |->
      first_timer_output_pin_o != $past(first_timer_output_pin_o))
      else $error("first output pin did not toggle on match");
   a_second_pin_toggle: assert property (second_timer_irq_o |->
      second_timer_output_pin_o != $past(second_timer_output_pin_o))
      else $error("second output pin did not toggle on match");
   a_pwm_pair_inverse: assert property (!pwm_oe_n_o && !$past(pwm_oe_n_o) && !$past(pwm_oe_n_o, 2) |->
      pwm_pins_o.ab == !pwm_pins_o.a && pwm_pins_o.bb == !pwm_pins_o.b && pwm_pins_o.cb == !pwm_pins_o.c)
      else $error("pwm pin pair not complementary");
   a_pwm_off_low: assert property (pwm_oe_n_o && $past(pwm_oe_n_o) && $past(pwm_oe_n_o, 2) |->
      pwm_pins_o == 6'h00)
      else $error("pwm pins active while disabled");
   a_pin_oe_excl: assert property (!second_timer_output_oe_n_o |-> pwm_oe_n_o)
      else $error("second timer pin enabled during pwm");
endmodule
bind dtp_top dtp_checker u_chk (.clk_i(clk_i), .reset_i(reset_i), .bus_i(bus_i), .rdata_o(rdata_o),
   .first_timer_irq_o(first_timer_irq_o), .second_timer_irq_o(second_timer_irq_o),
   .first_timer_output_pin_o(first_timer_output_pin_o), .second_timer_output_pin_o(second_timer_output_pin_o),
   .second_timer_output_oe_n_o(second_timer_output_oe_n_o), .pwm_pins_o(pwm_pins_o), .pwm_oe_n_o(pwm_oe_n_o));
`default_nettype wire

// [tb/dtp_pins_model.sv]
// Purpose: External pins: count pin and two capture triggers
// Assumes: Lines idle low, driven just after a rising edge
// Notes:   Pulses are 4 cycles high, 4 low, past the synchroniser
`timescale 1ns/10ps
`default_nettype none
module dtp_pins_model (
   // Clock
   input  wire logic  clk_i,
   // Pins: 0 count, 1 first trigger, 2 second trigger
   output logic [2:0] lines_o
);
   initial lines_o = 3'h0;
   task automatic pulse(input int sel);
      @(posedge clk_i);
      lines_o[sel] <= 1'b1;
      repeat (4) @(posedge clk_i);
      lines_o <= 3'h0;
      repeat (4) @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

// [tb/tb.sv]
// Purpose: Self-checking bench for the dual timer block
// Assumes: Register port with one-cycle strobes
// Notes:   Random values from an 8-bit shift register seeded at 60
`timescale 1ns/10ps
`default_nettype none
`include "dtp_consts.svh"
module tb;
   import dtp_pkg::*;
   logic          clk_i, reset_i;
   dtp_bus_req_t  bus;
   logic [7:0]    rdata, lf;
   logic [2:0]    lines;
   logic          ext_in, irq0, irq1, pin0, oe0, pin1, oe1, pwm_oe;
   dtp_pwm_pins_t pwm;
   int            miscompares, n_checks, irq1_cnt;
   dtp_top uut (.clk_i(clk_i), .reset_i(reset_i), .bus_i(bus), .rdata_o(rdata),
      .external_count_pin_i(lines[0]), .ext_count_input_o(ext_in),
      .first_capture_trigger_input_i(lines[1]), .second_capture_trigger_input_i(lines[2]),
      .first_timer_irq_o(irq0), .second_timer_irq_o(irq1), .first_timer_output_pin_o(pin0),
      .first_timer_output_oe_n_o(oe0), .second_timer_output_pin_o(pin1),
      .second_timer_output_oe_n_o(oe1), .pwm_pins_o(pwm), .pwm_oe_n_o(pwm_oe));
   dtp_pins_model pm (.clk_i(clk_i), .lines_o(lines));
   initial clk_i = 1'b0;
   always #2 clk_i = ~clk_i;
   always @(posedge clk_i) if (irq1 === 1'b1) irq1_cnt++;
   // ***************************************************
   // Helpers
   // ***************************************************
   function automatic logic [7:0] nxt(input logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction
   function automatic int per(input int m, input int d);
      return (m + 1) * d;
   endfunction
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tick;
      @(posedge clk_i);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      bus <= {a, d, 1'b1, 1'b0};
      @(posedge clk_i);
      bus.wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      bus <= {a, 8'h00, 1'b0, 1'b1};
      @(posedge clk_i);
      bus.rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   task automatic do_reset;
      @(posedge clk_i);
      reset_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      reset_i <= 1'b0;
   endtask
   task automatic gap(input int s, output int n);
      n = 0;
      while ((s ? irq1 : irq0) !== 1'b1 && n < 80000) begin
         tick;
         n++;
      end
      tick;
      n = 1;
      while ((s ? irq1 : irq0) !== 1'b1 && n < 80000) begin
         tick;
         n++;
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #360_000;
      miscompares++;
      close_out;
   end
   // ***************************************************
   // Tests
   // ***************************************************
   initial begin
      int i, k, n, m, na, nb, nc;
      logic [7:0] d, c, cap;
      logic [9:0] pp, da, db;
      int divs[7] = '{2, 4, 8, 32, 128, 512, 2048};
      reset_i = 1'b1;
      bus = '0;
      miscompares = 0;
      n_checks = 0;
      irq1_cnt = 0;
      lf = 8'h3C;
      do_reset;
      rd(`DTP_OFS_MODE, d);
      chk(d, 8'h00, "mode reset");
      rd(8'h0F, d);
      chk(d, 8'h00, "unmapped read");
      chk({pwm_oe, oe0, oe1, ext_in}, 4'hE, "enables reset");
      $display("test reset done");
      for (i = 0; i < 7; i++) begin
         lf = nxt(lf);
         m = 4 + lf[1:0];
         do_reset;
         wr(`DTP_OFS_T0_DATA, 8'(m));
         wr(`DTP_OFS_T1_DATA, 8'(m + 1));
         wr(`DTP_OFS_CLKSEL, {i[3:0], 1'b0, i[2:0]});
         wr(`DTP_OFS_MODE, 8'hF0);
         chk({oe0, oe1}, 2'b00, "timer pins on");
         gap(0, n);
         chk(16'(n), 16'(per(m, divs[i])), "first period");
         gap(1, n);
         chk(16'(n), 16'(per(m + 1, 1 << i)), "second period");
      end
      do_reset;
      wr(`DTP_OFS_T0_DATA, 8'h05);
      wr(`DTP_OFS_T1_DATA, 8'h06);
      wr(`DTP_OFS_CLKSEL, 8'hF0);
      wr(`DTP_OFS_MODE, 8'hC0);
      gap(1, n);
      chk(16'(n), 16'(per(6, per(5, 2))), "overflow clock");
      $display("test timers done");
      do_reset;
      lf = nxt(lf);
      m = 2 + lf[2:0];
      wr(`DTP_OFS_T0_DATA, 8'hFF);
      wr(`DTP_OFS_CLKSEL, 8'h07);
      wr(`DTP_OFS_MODE, 8'h40);
      chk(ext_in, 1'b1, "count pin input");
      repeat (m) pm.pulse(0);
      repeat (6) tick;
      rd(`DTP_OFS_T0_COUNT, d);
      chk(d, 8'(m), "edge count");
      do_reset;
      wr(`DTP_OFS_T0_DATA, 8'h01);
      wr(`DTP_OFS_T1_DATA, 8'h02);
      wr(`DTP_OFS_CLKSEL, 8'hF0);
      wr(`DTP_OFS_MODE, 8'hC1);
      k = irq1_cnt;
      gap(0, n);
      chk(16'(n), 16'(per(16'h0201, 2)), "joined period");
      chk(16'(irq1_cnt - k), 16'h0000, "joined second irq");
      $display("test count pin and join done");
      for (i = 0; i < 2; i++) begin
         do_reset;
         wr(`DTP_OFS_T0_DATA + 8'(i), 8'hC8);
         wr(`DTP_OFS_CLKSEL, 8'h10);
         wr(`DTP_OFS_MODE, (i != 0) ? 8'h84 : 8'h42);
         gap(i, n);
         chk(16'(n), 16'(per(200, 2)), "capture mode period");
         repeat (40) tick;
         rd(`DTP_OFS_T0_COUNT + 8'(i), c);
         pm.pulse(i + 1);
         rd(`DTP_OFS_T0_DATA + 8'(i), cap);
         chk(cap >= c && cap <= c + 8, 1'b1, "captured count");
         rd(`DTP_OFS_T0_COUNT + 8'(i), d);
         chk(d < cap, 1'b1, "counter restart");
      end
      $display("test capture done");
      for (i = 0; i < 2; i++) begin
         do_reset;
         lf = nxt(lf);
         d = 8'h80 | lf;
         pp = {2'b01, d};
         da = (i != 0) ? 10'h000 : {2'b00, nxt(lf)};
         db = {2'b01, d >> 1};
         wr(`DTP_OFS_PWM_PER, d);
         wr(`DTP_OFS_PWM_HIGH, 8'h15);
         wr(`DTP_OFS_DUTY_A, da[7:0]);
         wr(`DTP_OFS_DUTY_B, db[7:0]);
         wr(`DTP_OFS_DUTY_C, d);
         wr(`DTP_OFS_POLARITY, {5'h00, lf[2:0]});
         wr(`DTP_OFS_CLKSEL, 8'h00);
         wr(`DTP_OFS_MODE, 8'h88);
         chk({pwm_oe, oe1}, 2'b01, "pwm enables");
         repeat (1100) tick;
         na = 0;
         nb = 0;
         nc = 0;
         for (k = 0; k < pp; k++) begin
            tick;
            na += (pwm.a === lf[0]);
            nb += (pwm.b === lf[1]);
            nc += (pwm.c === lf[2]);
         end
         chk(16'(na), 16'(da), "duty a");
         chk(16'(nb), 16'(db), "duty b");
         chk(16'(nc), 16'(pp), "duty c full");
      end
      $display("test pwm done");
      close_out;
   end
endmodule
`default_nettype wire
